// [twl_regs.vh]
// Constants for the three-wire latch loader
`ifndef TWL_REGS_VH
`define TWL_REGS_VH
`define TWL_WORD_W      24
`define TWL_SEL_W       2
`define TWL_SEL_CTRL    2'h0
`define TWL_SEL_REFDIV  2'h1
`define TWL_SEL_FBDIV   2'h2
`define TWL_SEL_TEST    2'h3
`define TWL_LATCH_RST   24'h000000
`define TWL_PD_LSB      20
`define TWL_PD_MSB      21
`define TWL_MUX_LSB     5
`define TWL_MUX_MSB     7
`define TWL_MUX_LOCK    3'h1
`define TWL_MUX_FBDIV   3'h2
`define TWL_MUX_REFDIV  3'h4
`define TWL_PD_RUN      2'h0
`define TWL_SYNC3_RST   3'h0
`define TWL_SYNC2_RST   2'h0
`endif

// [twl_loader.v]
// Three-wire serial programming port with four load latches
//
// How it works
// - Each rising serial clock edge shifts the data pin into the 24-bit register.
// - Two lowest word bits select the target latch; host sets, device decodes.
// - Rising load strobe copies the shift register into the selected latch.
// - Chip enable low powers down and three-states the pump output.
// - Chip enable high powers up only when programmed power-down bits allow.
// - Observe output shows lock detect, scaled feedback or scaled reference.
// - Select 0 control, 1 reference divider, 2 feedback divider, 3 test latch.
`timescale 1ns/1ps
`include "twl_regs.vh"

module twl_loader (
   input  wire        mclk_in,
   input  wire        resetn_in,
   input  wire        sclk_in,
   input  wire        sdata_in,
   input  wire        load_strobe_in,
   input  wire        chip_enable_in,
   input  wire        lock_detect_in,
   input  wire        fb_scaled_in,
   input  wire        ref_scaled_in,
   output reg  [23:0] ctrl_latch_out,
   output reg  [23:0] refdiv_latch_out,
   output reg  [23:0] fbdiv_latch_out,
   output reg  [23:0] test_latch_out,
   output reg         powered_up_out,
   output reg         pump_output_oe_out,
   output reg         observe_output_out
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Stage 1 is read only by the next stage; edge logic uses stage 2 and 3.
   reg [2:0] sclk_sync;
   reg [2:0] le_sync;
   reg [1:0] data_sync;
   reg [1:0] ce_sync;
   reg [1:0] lock_sync;
   reg [1:0] fb_sync;
   reg [1:0] ref_sync;

   // Serial clock needs a third stage so its edge can be found
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sclk_sync <= `TWL_SYNC3_RST;
      end else begin
         sclk_sync <= {sclk_sync[1:0], sclk_in};
      end
   end

   // Load strobe likewise carries a third stage for its edge
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         le_sync <= `TWL_SYNC3_RST;
      end else begin
         le_sync <= {le_sync[1:0], load_strobe_in};
      end
   end

   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         data_sync <= `TWL_SYNC2_RST;
      end else begin
         data_sync <= {data_sync[0], sdata_in};
      end
   end

   // Chip enable resets low so the pump stays off until the pin is seen high
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ce_sync <= `TWL_SYNC2_RST;
      end else begin
         ce_sync <= {ce_sync[0], chip_enable_in};
      end
   end

   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lock_sync <= `TWL_SYNC2_RST;
      end else begin
         lock_sync <= {lock_sync[0], lock_detect_in};
      end
   end

   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fb_sync <= `TWL_SYNC2_RST;
      end else begin
         fb_sync <= {fb_sync[0], fb_scaled_in};
      end
   end

   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ref_sync <= `TWL_SYNC2_RST;
      end else begin
         ref_sync <= {ref_sync[0], ref_scaled_in};
      end
   end

   // Data is sampled with the clock edge delayed equally, so setup is kept.
   wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   wire le_rise   = le_sync[1] & ~le_sync[2];

   // ----------------------------------------------------------------
   // Shift register and latches
   // ----------------------------------------------------------------
   reg [23:0] shift_word;
   wire [23:0] next_shift = {shift_word[22:0], data_sync[1]};
   wire [1:0]  word_sel   = shift_word[`TWL_SEL_W-1:0];

   // Shared by all four latch loads so the select decode stays in one place
   function load_hit;
      input       strobe;
      input [1:0] sel;
      input [1:0] code;
      begin
         load_hit = strobe & (sel == code);
      end
   endfunction

   // Extra edges simply push old bits out of the top
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         shift_word <= `TWL_LATCH_RST;
      end else if (sclk_rise) begin
         shift_word <= next_shift;
      end
   end

   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_latch_out <= `TWL_LATCH_RST;
      end else if (load_hit(le_rise, word_sel, `TWL_SEL_CTRL)) begin
         ctrl_latch_out <= shift_word;
      end
   end

   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         refdiv_latch_out <= `TWL_LATCH_RST;
      end else if (load_hit(le_rise, word_sel, `TWL_SEL_REFDIV)) begin
         refdiv_latch_out <= shift_word;
      end
   end

   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fbdiv_latch_out <= `TWL_LATCH_RST;
      end else if (load_hit(le_rise, word_sel, `TWL_SEL_FBDIV)) begin
         fbdiv_latch_out <= shift_word;
      end
   end

   // Kept for completeness; hosts must not load it
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         test_latch_out <= `TWL_LATCH_RST;
      end else if (load_hit(le_rise, word_sel, `TWL_SEL_TEST)) begin
         test_latch_out <= shift_word;
      end
   end

   // ----------------------------------------------------------------
   // Power control and observe output
   // ----------------------------------------------------------------
   wire [1:0] pd_bits  = ctrl_latch_out[`TWL_PD_MSB:`TWL_PD_LSB];
   wire       run      = ce_sync[1] & (pd_bits == `TWL_PD_RUN);
   wire [2:0] mux_sel  = ctrl_latch_out[`TWL_MUX_MSB:`TWL_MUX_LSB];
   reg        next_obs;

   always @* begin
      case (mux_sel)
         `TWL_MUX_LOCK:   next_obs = lock_sync[1];
         `TWL_MUX_FBDIV:  next_obs = fb_sync[1];
         `TWL_MUX_REFDIV: next_obs = ref_sync[1];
         default:         next_obs = 1'b0;
      endcase
   end

   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         powered_up_out <= 1'b0;
      end else begin
         powered_up_out <= run;
      end
   end

   // Pump stays three-stated whenever the part is not running
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pump_output_oe_out <= 1'b0;
      end else begin
         pump_output_oe_out <= run;
      end
   end

   // Forced low when powered down so a stale source never leaks out
   always @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         observe_output_out <= 1'b0;
      end else begin
         observe_output_out <= run ? next_obs : 1'b0;
      end
   end

endmodule // twl_loader

// [twl_loader_monitor.sv]
// Port checker for the latch loader
`timescale 1ns/1ps
module twl_loader_monitor(input wire mclk_in, resetn_in, load_strobe_in, chip_enable_in,
   lock_detect_in, powered_up_out, pump_output_oe_out, observe_output_out,
   input wire [23:0] ctrl_latch_out, refdiv_latch_out, fbdiv_latch_out);
   wire [23:0] c = ctrl_latch_out, r = refdiv_latch_out, f = fbdiv_latch_out;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_off; !chip_enable_in[*4]; endsequence
   a_pump_off: assert property (s_off |=> !pump_output_oe_out) else $error("pump");
   a_obs_off: assert property (s_off |=> !observe_output_out) else $error("obs");
   a_pd_gate: assert property (powered_up_out |-> $past(c[21:20]) == 2'h0)
      else $error("pd");
   a_obs_lock: assert property ((powered_up_out && c[7:5] == 3'h1 && lock_detect_in)[*4]
      |-> observe_output_out) else $error("lock");
   a_sel_ctrl: assert property ($changed(c) |-> c[1:0] == 2'h0) else $error("sel");
   a_sel_ref: assert property ($changed(r) |-> r[1:0] == 2'h1) else $error("sel");
   a_sel_fb: assert property ($changed(f) |-> f[1:0] == 2'h2) else $error("sel");
   a_load_src: assert property ($changed({c, r, f})
      |-> $past(load_strobe_in, 2) || $past(load_strobe_in, 3)) else $error("load");
endmodule // twl_loader_monitor

// [twl_host.sv]
// Host model for the serial programming pins
`timescale 1ns/1ps
module twl_host(input wire mclk_in, output reg sclk_out = 1'h0, sdata_out = 1'h0, le_out = 1'h0);
   task send(input [23:0] w, input integer extra);
      for (int i = extra + 23; i >= 0; i--) begin
         #100 sdata_out = (i > 23) ? i[0] : w[i];
         #300 sclk_out = 1'h1;
         #400 sclk_out = 1'h0;
         sdata_out = ~sdata_out; // Past hold time the line shows a fresh level
      end
      #400 le_out = 1'h1;
      #800 le_out = 1'h0;
   endtask
endmodule // twl_host

// [tb_twl_loader.sv]
// Testbench for the three-wire latch loader
`timescale 1ns/1ps
module tb_twl_loader;
   reg         mclk_in = 1'h0, resetn_in = 1'h0, chip_enable_in = 1'h1;
   reg         fb_scaled_in = 1'h0, ref_scaled_in = 1'h0;
   wire        sclk_in, sdata_in, load_strobe_in, powered_up_out, pump_output_oe_out;
   wire        observe_output_out;
   wire        lock_detect_in = chip_enable_in;
   wire [23:0] ctrl_latch_out, refdiv_latch_out, fbdiv_latch_out, test_latch_out;
   wire [74:0] st = {powered_up_out, pump_output_oe_out, observe_output_out, ctrl_latch_out,
                     refdiv_latch_out, fbdiv_latch_out};
   integer     n_errors = 0, num_checks = 0;
   initial forever #50 mclk_in = ~mclk_in;
   twl_host i_host(.mclk_in, .sclk_out(sclk_in), .sdata_out(sdata_in), .le_out(load_strobe_in));
   twl_loader i_dut(.*);
   task chk(input [74:0] got, exp);
      num_checks++;
      n_errors += (got !== exp);
      if (got !== exp) $display("[FAIL] %0t %h %h", $time, got, exp);
   endtask
   task test_done;
      $display("%0d checks %0d errors", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task t_power_up;
      i_host.send(24'h00AB05, 0);
      i_host.send(24'h000020, 0);
      i_host.send(24'hA5C3E6, 5);
      chk(st, {3'h7, 24'h000020, 24'h00AB05, 24'hA5C3E6});
      chk(test_latch_out, 24'h000000);
   endtask
   task t_observe;
      fb_scaled_in = 1'h1;
      i_host.send(24'h000040, 0);
      chk(st, {3'h7, 24'h000040, 24'h00AB05, 24'hA5C3E6});
      i_host.send(24'h000080, 0);
      chk(st, {3'h6, 24'h000080, 24'h00AB05, 24'hA5C3E6});
      ref_scaled_in = 1'h1;
      repeat (4) @(negedge mclk_in);
      chk(st, {3'h7, 24'h000080, 24'h00AB05, 24'hA5C3E6});
   endtask
   task t_chip_off;
      chip_enable_in = 1'h0;
      i_host.send(24'h300020, 0);
      chk(st, {3'h0, 24'h300020, 24'h00AB05, 24'hA5C3E6});
      chip_enable_in = 1'h1;
      repeat (6) @(negedge mclk_in);
      chk(st, {3'h0, 24'h300020, 24'h00AB05, 24'hA5C3E6});
   endtask
   initial begin
      repeat (4) @(negedge mclk_in);
      resetn_in = 1'h1;
      t_power_up;
      t_observe;
      t_chip_off;
      test_done;
   end
endmodule // tb_twl_loader
bind twl_loader twl_loader_monitor i_mon(.*);
